//--- dma_completion_interrupt_logic.sv
// completion interrupt logic: pending/enable vectors, region access views, AXI4-Lite slave
// completion codes arrive from the transfer engine on clk_sys, one per cycle at most
// Notes on behaviour
// - codes 0-31 set pending low bits, 32-63 set pending high bits 0-31.
// - any code from any channel accepted; many channels may share one bit.
// - final enable sets pending when the last request is submitted or completed.
// - intermediate enable sets pending after every request except the last.
// - both enables set pending after every request including the last.
// - one request per array or per frame; interrupts follow those request counts.
// - a returned code sets pending only with final or intermediate enable set.
// - each enable bit masks the pending bit at the same position.
// - global interrupt is OR over 64 of pending AND enable.
// - region k interrupt also ANDs region k access bits, through bit 63.
// - global and shadow views reach one shared physical register set.
// - writing 1 to pending-clear clears that pending bit; 0 does nothing.
// - apart from evaluate, pulse only when enabled-pending goes from none to some.
// - writing the evaluate bit re-pulses the interrupt if any enabled bit pends.
// - eight shadow-region interrupts plus one global completion interrupt.
// - in a shadow view, bits without access read zero and ignore writes.
// - shadow evaluate register works regardless of access-enable bits.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "dma_irq_consts.svh"
module dma_completion_interrupt_logic
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cplValid,
  input wire dma_irq_pkg::code_t cplCode,
  input wire logic cplLast,
  input wire logic cplFinalEn,
  input wire logic cplInterEn,
  output logic globalCompletionIrq,
  output logic [7:0] regionCompletionIrq
);
  dma_irq_pkg::vec64_t pending;
  dma_irq_pkg::vec64_t irqEnable;
  dma_irq_pkg::vec64_t regionAccess [`REGION_COUNT];
  logic [`ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wrDo;
  logic [31:0] wrWord;
  dma_irq_pkg::vec64_t wrMask;
  dma_irq_pkg::vec64_t pendClr;
  dma_irq_pkg::vec64_t enSet;
  dma_irq_pkg::vec64_t enClr;
  dma_irq_pkg::vec64_t cplSet;
  logic [8:0] evalReq;
  logic accessWe;
  logic [2:0] accessIdx;
  logic accessHigh;
  logic wrOk;
  logic [31:0] rdWord;
  logic rdOk;
  irq_pulse_if lanes ();

  irq_pulse_gen u_pulse
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .lanes(lanes)
  );

  // a returned code lands on its own bit whatever channel sent it
  always_comb
  begin
    cplSet = `RST_VEC64;
    // the engine flags the last request of a channel; enables come from its options
    if (cplValid && ((cplLast && cplFinalEn) || (!cplLast && cplInterEn)))
    begin
      cplSet[cplCode] = 1'b1;
    end
  end

  // shadow views are windows onto the same registers, filtered by access bits
  always_comb
  begin
    logic [3:0] region;
    logic [7:0] off;
    dma_irq_pkg::vec64_t amask;
    logic [31:0] lanesMask;
    region = awAddr[`ADDR_W-1:`REGION_LSB];
    off = awAddr[`REGION_LSB-1:0];
    amask = '1;
    lanesMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
    wrWord = wData & lanesMask;
    pendClr = `RST_VEC64;
    enSet = `RST_VEC64;
    enClr = `RST_VEC64;
    evalReq = 9'h000;
    accessWe = 1'b0;
    accessIdx = off[5:3];
    accessHigh = off[2];
    wrOk = 1'b1;
    if (region > 4'h0 && region <= 4'h8)
    begin
      amask = regionAccess[3'(region - 4'h1)];
    end
    wrMask = amask;
    if (region > 4'h8)
    begin
      wrOk = 1'b0;
    end
    else if (region == 4'h0 && off >= `OFF_ACCESS_BASE && off <= `OFF_ACCESS_LAST)
    begin
      accessWe = wrDo;
    end
    else
    begin
      unique case (off)
        `OFF_PENDING_CLEAR_LOW: pendClr = {32'h0, wrWord} & amask;
        `OFF_PENDING_CLEAR_HIGH: pendClr = {wrWord, 32'h0} & amask;
        `OFF_IRQ_ENABLE_SET_LOW: enSet = {32'h0, wrWord} & amask;
        `OFF_IRQ_ENABLE_SET_HIGH: enSet = {wrWord, 32'h0} & amask;
        `OFF_IRQ_ENABLE_CLEAR_LOW: enClr = {32'h0, wrWord} & amask;
        `OFF_IRQ_ENABLE_CLEAR_HIGH: enClr = {wrWord, 32'h0} & amask;
        // evaluate is never filtered by the access bits of its region
        `OFF_IRQ_EVALUATE: evalReq[region] = wrWord[`EVALUATE_BIT];
        `OFF_PENDING_LOW, `OFF_PENDING_HIGH, `OFF_IRQ_ENABLE_LOW, `OFF_IRQ_ENABLE_HIGH: ;
        default: wrOk = 1'b0;
      endcase
    end
    if (!wrDo)
    begin
      pendClr = `RST_VEC64;
      enSet = `RST_VEC64;
      enClr = `RST_VEC64;
      evalReq = 9'h000;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pending <= `RST_VEC64;
    end
    else
    begin
      // a code arriving with its clear still sets the bit
      pending <= (pending & ~pendClr) | cplSet;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqEnable <= `RST_VEC64;
    end
    else
    begin
      irqEnable <= (irqEnable | enSet) & ~enClr;
    end
  end

  for (genvar k = 0; k < `REGION_COUNT; k++)
  begin : g_access
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        regionAccess[k] <= `RST_VEC64;
      end
      else if (accessWe && accessIdx == 3'(k))
      begin
        if (accessHigh)
        begin
          // unstrobed lanes keep their old access bits, as in the low word
          regionAccess[k][63:32] <= wData & {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}},
            {8{wStrb[0]}}} | (regionAccess[k][63:32] & ~{{8{wStrb[3]}}, {8{wStrb[2]}},
            {8{wStrb[1]}}, {8{wStrb[0]}}});
        end
        else
        begin
          regionAccess[k][31:0] <= wData & {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}},
            {8{wStrb[0]}}} | (regionAccess[k][31:0] & ~{{8{wStrb[3]}}, {8{wStrb[2]}},
            {8{wStrb[1]}}, {8{wStrb[0]}}});
        end
      end
    end
    // region lane sees pending AND enable AND its own access bits
    assign lanes.level[k + 1] = |(pending & irqEnable & regionAccess[k]);
  end

  assign lanes.level[0] = |(pending & irqEnable);
  assign lanes.evaluate_bit = evalReq;
  assign globalCompletionIrq = lanes.pulse[0];
  assign regionCompletionIrq = lanes.pulse[8:1];

  // write channel: address and data taken in either order, answered after both
  assign wrDo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dma_irq_pkg::RESP_OKAY;
      awAddr <= '0;
      wData <= `RST_WORD;
      wStrb <= 4'h0;
    end
    else
    begin
      if (s_axi_awready && s_axi_awvalid)
      begin
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrDo)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? dma_irq_pkg::RESP_OKAY : dma_irq_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read decode, same view filtering as writes
  always_comb
  begin
    logic [3:0] region;
    logic [7:0] off;
    dma_irq_pkg::vec64_t amask;
    dma_irq_pkg::vec64_t acc;
    region = s_axi_araddr[`ADDR_W-1:`REGION_LSB];
    off = s_axi_araddr[`REGION_LSB-1:0];
    amask = '1;
    acc = regionAccess[off[5:3]];
    rdWord = `RST_WORD;
    rdOk = 1'b1;
    if (region > 4'h0 && region <= 4'h8)
    begin
      amask = regionAccess[3'(region - 4'h1)];
    end
    if (region > 4'h8)
    begin
      rdOk = 1'b0;
    end
    else if (region == 4'h0 && off >= `OFF_ACCESS_BASE && off <= `OFF_ACCESS_LAST)
    begin
      rdWord = off[2] ? acc[63:32] : acc[31:0];
    end
    else
    begin
      unique case (off)
        `OFF_PENDING_LOW: rdWord = pending[31:0] & amask[31:0];
        `OFF_PENDING_HIGH: rdWord = pending[63:32] & amask[63:32];
        `OFF_IRQ_ENABLE_LOW: rdWord = irqEnable[31:0] & amask[31:0];
        `OFF_IRQ_ENABLE_HIGH: rdWord = irqEnable[63:32] & amask[63:32];
        `OFF_PENDING_CLEAR_LOW, `OFF_PENDING_CLEAR_HIGH, `OFF_IRQ_ENABLE_SET_LOW,
        `OFF_IRQ_ENABLE_SET_HIGH, `OFF_IRQ_ENABLE_CLEAR_LOW, `OFF_IRQ_ENABLE_CLEAR_HIGH,
        `OFF_IRQ_EVALUATE: rdWord = `RST_WORD;
        default: rdOk = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RST_WORD;
      s_axi_rresp <= dma_irq_pkg::RESP_OKAY;
    end
    else if (s_axi_arready && s_axi_arvalid)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= rdOk ? dma_irq_pkg::RESP_OKAY : dma_irq_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

//--- dma_completion_interrupt_logic_tb.sv
// self-checking bench: random and corner completion codes, AXI4-Lite register traffic
// irq_host_model counts the pulses; one clock at 125 MHz
`timescale 1ns/1ns
`include "dma_irq_consts.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module dma_completion_interrupt_logic_tb;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
  logic awReady, wReady, bValid, arReady, rValid, gIrq, clr = 1'h0;
  logic cplValid = 1'h0, cplLast = 1'h0, cplFin = 1'h0, cplInt = 1'h0;
  logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
  logic [31:0] wData = 32'h0, rData, seed = 32'h0000ADE3;
  logic [1:0] bResp, rResp, lastR, lastB;
  logic [7:0] rIrq;
  dma_irq_pkg::code_t cplCode = 6'h00;
  int failures = 0, num_checks = 0, gCnt, rCnt [8];
  dma_completion_interrupt_logic uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .cplValid(cplValid), .cplCode(cplCode), .cplLast(cplLast), .cplFinalEn(cplFin),
    .cplInterEn(cplInt), .globalCompletionIrq(gIrq), .regionCompletionIrq(rIrq));
  irq_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .clear(clr), .globalIrq(gIrq),
    .regionIrq(rIrq), .globalCount(gCnt), .regionCount(rCnt));
  initial forever #4 clk_sys = ~clk_sys;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic takes(logic l, logic f, logic i);
    return (l && f) || (!l && i);
  endfunction
  function automatic logic [11:0] at(int v, logic [7:0] o);
    return {4'(v), o};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awAddr <= a;
    wData <= d;
    awValid <= 1'h1;
    wValid <= 1'h1;
    bReady <= 1'h1;
    @(negedge clk_sys);
    while (!(awReady && wReady)) @(negedge clk_sys);
    @(posedge clk_sys);
    awValid <= 1'h0;
    wValid <= 1'h0;
    @(negedge clk_sys);
    while (!bValid) @(negedge clk_sys);
    @(posedge clk_sys);
    lastB = bResp;
    bReady <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    arAddr <= a;
    arValid <= 1'h1;
    @(negedge clk_sys);
    while (!arReady) @(negedge clk_sys);
    @(posedge clk_sys);
    arValid <= 1'h0;
    @(negedge clk_sys);
    while (!rValid) @(negedge clk_sys);
    // late rready keeps the read answer standing for a cycle
    @(posedge clk_sys);
    rReady <= 1'h1;
    // data are taken at the handshake edge itself
    @(posedge clk_sys);
    d = rData;
    lastR = rResp;
    rReady <= 1'h0;
  endtask
  task automatic cpl(input int c, input logic l, input logic f, input logic i);
    @(posedge clk_sys);
    cplCode <= 6'(c);
    cplLast <= l;
    cplFin <= f;
    cplInt <= i;
    cplValid <= 1'h1;
    @(posedge clk_sys);
    cplValid <= 1'h0;
  endtask
  task automatic chkPend(input int v, input logic [63:0] x);
    logic [31:0] d;
    rd(at(v, `OFF_PENDING_LOW), d);
    `CHK(d, x[31:0])
    rd(at(v, `OFF_PENDING_HIGH), d);
    `CHK(d, x[63:32])
  endtask
  task automatic zap();
    @(posedge clk_sys);
    clr <= 1'h1;
    @(posedge clk_sys);
    clr <= 1'h0;
  endtask
  task automatic conclude();
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    failures++;
    conclude();
  end
  initial
  begin
    logic [31:0] d, m;
    logic [63:0] e;
    logic [2:0] b;
    int c, n;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    for (int o = 0; o <= 8'h2C; o += 4)
    begin
      rd(at(0, 8'(o)), d);
      `CHK(d, `RST_WORD)
      `CHK(lastR, (o == 8'h2C) ? dma_irq_pkg::RESP_SLVERR : dma_irq_pkg::RESP_OKAY)
    end
    $display("reset values done");
    m = rnd();
    wr(at(9, `OFF_IRQ_ENABLE_SET_LOW), 32'hFFFFFFFF);
    `CHK(lastB, dma_irq_pkg::RESP_SLVERR)
    wr(at(0, `OFF_IRQ_ENABLE_SET_LOW), m);
    `CHK(lastB, dma_irq_pkg::RESP_OKAY)
    wr(at(0, `OFF_IRQ_ENABLE_CLEAR_LOW), m & 32'h0000FFFF);
    rd(at(0, `OFF_IRQ_ENABLE_LOW), d);
    `CHK(d, m & 32'hFFFF0000)
    wr(at(0, `OFF_IRQ_ENABLE_SET_LOW), 32'hFFFFFFFF);
    wr(at(0, `OFF_IRQ_ENABLE_SET_HIGH), 32'hFFFFFFFF);
    e = `RST_VEC64;
    for (n = 0; n < 44; n++)
    begin
      c = (n < 4) ? (n[0] * 31 + n[1] * 32) : int'(rnd() % 64);
      b = (n < 4) ? 3'h7 : 3'(rnd());
      cpl(c, b[0], b[1], b[2]);
      if (takes(b[0], b[1], b[2]))
        e[c] = 1'h1;
    end
    chkPend(0, e);
    m = rnd();
    wr(at(0, `OFF_PENDING_CLEAR_LOW), m);
    wr(at(0, `OFF_PENDING_CLEAR_HIGH), ~m);
    chkPend(0, e & ~{~m, m});
    wr(at(0, `OFF_PENDING_CLEAR_LOW), 32'hFFFFFFFF);
    wr(at(0, `OFF_PENDING_CLEAR_HIGH), 32'hFFFFFFFF);
    $display("pending map done");
    for (int mode = 1; mode < 4; mode++)
    begin
      n = 0;
      zap();
      for (int t = 0; t < 5; t++)
      begin
        cpl(30, t == 4, mode[0], mode[1]);
        n += takes(t == 4, mode[0], mode[1]);
        wr(at(0, `OFF_PENDING_CLEAR_LOW), 32'hFFFFFFFF);
      end
      `CHK(gCnt, n)
    end
    zap();
    for (int t = 1; t < 4; t++)
      cpl(t, 1'h0, 1'h0, 1'h1);
    repeat (2) @(posedge clk_sys);
    `CHK(gCnt, 1)
    wr(at(0, `OFF_IRQ_EVALUATE), 32'h1);
    repeat (2) @(posedge clk_sys);
    `CHK(gCnt, 2)
    wr(at(0, `OFF_PENDING_CLEAR_LOW), 32'hFFFFFFFF);
    wr(at(0, `OFF_IRQ_EVALUATE), 32'h1);
    repeat (2) @(posedge clk_sys);
    `CHK(gCnt, 2)
    `CHK(rCnt[0], 0)
    $display("pulse rules done");
    for (int k = 0; k < 8; k++)
    begin
      wr(at(0, `OFF_ACCESS_BASE + 8'(8 * k)), 32'h1 << k);
      zap();
      cpl(k, 1'h1, 1'h1, 1'h0);
      repeat (2) @(posedge clk_sys);
      chkPend(k + 1, 64'h1 << k);
      chkPend((k + 1) % 8 + 1, `RST_VEC64);
      `CHK(rCnt[k], 1)
      `CHK(rCnt[(k + 1) % 8], 0)
      `CHK(gCnt, 1)
      wr(at(k + 1, `OFF_PENDING_CLEAR_LOW), 32'hFFFFFFFF);
      chkPend(0, `RST_VEC64);
    end
    $display("region views done");
    conclude();
  end
endmodule

//--- dma_irq_consts.svh
// register offsets, region layout and reset values of the completion interrupt block
// assumes a 12-bit byte address with 32-bit aligned registers
`ifndef DMA_IRQ_CONSTS_SVH
`define DMA_IRQ_CONSTS_SVH
`define ADDR_W 12
`define REGION_LSB 8
`define REGION_COUNT 8
`define OFF_PENDING_LOW 8'h00
`define OFF_PENDING_HIGH 8'h04
`define OFF_PENDING_CLEAR_LOW 8'h08
`define OFF_PENDING_CLEAR_HIGH 8'h0C
`define OFF_IRQ_ENABLE_LOW 8'h10
`define OFF_IRQ_ENABLE_HIGH 8'h14
`define OFF_IRQ_ENABLE_SET_LOW 8'h18
`define OFF_IRQ_ENABLE_SET_HIGH 8'h1C
`define OFF_IRQ_ENABLE_CLEAR_LOW 8'h20
`define OFF_IRQ_ENABLE_CLEAR_HIGH 8'h24
`define OFF_IRQ_EVALUATE 8'h28
`define OFF_ACCESS_BASE 8'h40
`define OFF_ACCESS_LAST 8'h7C
`define EVALUATE_BIT 0
`define RST_VEC64 64'h0000000000000000
`define RST_WORD 32'h00000000
`endif

//--- dma_irq_pkg.sv
// types shared by the completion interrupt block
// constants live in dma_irq_consts.svh
package dma_irq_pkg;
  typedef logic [63:0] vec64_t;
  typedef logic [5:0] code_t;
  typedef logic [3:0] region_t;
  typedef enum logic [1:0]
  {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } resp_e;
endpackage

//--- dma_irq_properties.sv
// port-level assertions for the completion interrupt block
// bound into every instance of dma_completion_interrupt_logic
`timescale 1ns/1ns
module dma_irq_properties
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cplValid,
  input wire logic globalCompletionIrq,
  input wire logic [7:0] regionCompletionIrq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wrAnswer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  chk_write_answer: assert property (wrTaken |=> wrAnswer)
    else $error("write response not on time");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response not on time");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed before handshake");
  chk_reset_quiet: assert property ($rose(rst_n) |-> (!globalCompletionIrq) [*2])
    else $error("interrupt right after reset");
  chk_global_single: assert property (globalCompletionIrq |=> !globalCompletionIrq)
    else $error("global pulse longer than one cycle");
  chk_region_single: assert property (|regionCompletionIrq |=>
    !(|(regionCompletionIrq & $past(regionCompletionIrq))))
    else $error("region pulse longer than one cycle");
  // an evaluate pulse stands together with the write response of its write
  chk_global_cause: assert property (globalCompletionIrq |->
    $past(cplValid, 2) || s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("global pulse without cause");
  chk_region_cause: assert property (|regionCompletionIrq |->
    $past(cplValid, 2) || s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("region pulse without cause");
endmodule
bind dma_completion_interrupt_logic dma_irq_properties chk (.*);

//--- irq_host_model.sv
// host interrupt controller model: counts pulses on the nine completion lines
// runs on clk_sys; the bench zeroes the counts with clear
`timescale 1ns/1ns
module irq_host_model
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic globalIrq,
  input wire logic [7:0] regionIrq,
  output int globalCount,
  output int regionCount [8]
);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      globalCount <= 0;
      regionCount <= '{default: 0};
    end
    else if (clear)
    begin
      globalCount <= 0;
      regionCount <= '{default: 0};
    end
    else
    begin
      globalCount <= globalCount + int'(globalIrq);
      for (int k = 0; k < 8; k++)
        regionCount[k] <= regionCount[k] + int'(regionIrq[k]);
    end
  end
endmodule

//--- irq_pulse_gen.sv
// one-cycle interrupt pulse per lane on a rising enabled-pending level or an evaluate request while the level is set
// level and evaluate_bit come from logic on clk_sys
`timescale 1ns/1ns
module irq_pulse_gen
(
  input wire logic clk_sys,
  input wire logic rst_n,
  irq_pulse_if.gen lanes
);
  logic [8:0] levelPrev;

  for (genvar i = 0; i < 9; i++)
  begin : g_lane
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        levelPrev[i] <= 1'b0;
        lanes.pulse[i] <= 1'b0;
      end
      else
      begin
        levelPrev[i] <= lanes.level[i];
        // new bits while already pending give no pulse; evaluate re-pulses if still pending
        lanes.pulse[i] <= (lanes.level[i] & ~levelPrev[i]) | (lanes.evaluate_bit[i] & lanes.level[i]);
      end
    end
  end
endmodule

//--- irq_pulse_if.sv
// level, evaluate and pulse lanes between the register core and the pulse generator
// lane 0 is the global interrupt, lanes 1 to 8 the shadow regions
`timescale 1ns/1ns
interface irq_pulse_if;
  logic [8:0] level;
  logic [8:0] evaluate_bit;
  logic [8:0] pulse;
  modport gen
  (
    input level,
    input evaluate_bit,
    output pulse
  );
  modport core
  (
    output level,
    output evaluate_bit,
    input pulse
  );
endinterface
